/* fpsfl_pkg.sv */
//==============================================================================
// Summary of operation
// - Six sticky exception flags in low bits.
// - Summary bit 7 set by unmasked flag.
// - Masked exception sets flag, not summary.
// - Set summary bit requests exception handling.
// - Flags sticky; cleared by clear, reinit, save.
// - Bit 15 mirrors the summary bit.
// - Compare: result in bits 0/3, 2 unordered.
// - Compare-to-flags: bit 1 reports stack fault only.
// - Remainder: quotient bits, bit 2 incomplete reduction.
// - Arithmetic: bit 1 round-up or stack fault.
// - Trig: bit 2 out of range, bit 1 round-up.
// - Loads and moves: bit 1 zero unless fault.
// - Environment load sets condition bits from image.
// - Control instructions leave condition bits unchanged.
// - Stack fault bit 6 set on overflow/underflow.
// - With stack fault, bit 1 gives fault type.
// - Stack fault sticky until explicit clear.
// - Top-of-stack number in bits 11 to 13.
// - Masks come from control word bits 0-5.
// - Examine: C1 sign, others operand class.
//==============================================================================
package fpsfl_pkg;
  // Status word field positions.
  localparam int FLAG_LSB = 0;
  localparam int FLAG_W = 6;
  localparam int STACK_FAULT_POS = 6;
  localparam int SUMMARY_POS = 7;
  localparam int COND0_POS = 8;
  localparam int COND1_POS = 9;
  localparam int COND2_POS = 10;
  localparam int TOP_LSB = 11;
  localparam int COND3_POS = 14;
  localparam int B_POS = 15;
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [5:0] MASK_RESET = 6'h3f;
  localparam logic [2:0] TOP_RESET = 3'h0;

  // Instruction class reported by the datapath.
  typedef enum logic [3:0] {
    FPSFL_NONE, FPSFL_COMPARE_CC, FPSFL_COMPARE_FLAGS, FPSFL_EXAMINE,
    FPSFL_REMAINDER, FPSFL_ARITH, FPSFL_TRIG, FPSFL_LOADMOVE,
    FPSFL_ENV_LOAD, FPSFL_CONTROL, FPSFL_CLEAR, FPSFL_REINIT, FPSFL_SAVE
  } fpsfl_class_t;

  // One completed instruction from the datapath.
  typedef struct packed {
    logic valid;
    fpsfl_class_t cls;
    logic [5:0] exc;
    logic stack_fault;
    logic stack_over;
    logic [3:0] cc;
    logic top_we;
    logic [2:0] top;
    logic [15:0] image;
  } fpsfl_op_t;
endpackage : fpsfl_pkg

/* fpsfl_cc_sel.sv */
`timescale 1ns/1ps
// Combinational condition-code selector; cc is {bit3,bit2,bit1,bit0}.
module fpsfl_cc_sel
  import fpsfl_pkg::*;
(
  // Inputs
  input wire fpsfl_op_t op,
  input wire logic [3:0] cur,
  // Outputs
  output logic [3:0] next_cc
);
  // Datapath supplies cc as {bit3,bit2,bit1,bit0} with class meaning applied here.
  wire logic c1_fault = op.stack_over;
  always_comb
  begin
    next_cc = cur;
    // An idle bus must never move the codes, whatever class it still shows.
    unique case (op.valid ? op.cls : FPSFL_NONE)
      FPSFL_COMPARE_CC: next_cc = {op.cc[3], op.cc[2],
        op.stack_fault ? c1_fault : 1'b0, op.cc[0]};
      FPSFL_COMPARE_FLAGS: next_cc = {cur[3], cur[2],
        op.stack_fault ? c1_fault : 1'b0, cur[0]};
      FPSFL_EXAMINE: next_cc = op.cc;
      FPSFL_REMAINDER: next_cc = {op.cc[3], op.cc[2],
        op.stack_fault ? c1_fault : op.cc[1], op.cc[0]};
      FPSFL_ARITH: next_cc = {cur[3], cur[2],
        op.stack_fault ? c1_fault : op.cc[1], cur[0]};
      FPSFL_TRIG: next_cc = {cur[3], op.cc[2],
        op.stack_fault ? c1_fault : op.cc[1], cur[0]};
      FPSFL_LOADMOVE: next_cc = {cur[3], cur[2],
        op.stack_fault ? c1_fault : 1'b0, cur[0]};
      FPSFL_ENV_LOAD: next_cc = {op.image[COND3_POS], op.image[COND2_POS],
        op.image[COND1_POS], op.image[COND0_POS]};
      FPSFL_REINIT, FPSFL_SAVE: next_cc = 4'h0;
      FPSFL_NONE, FPSFL_CONTROL, FPSFL_CLEAR: next_cc = cur;
      default: next_cc = cur;
    endcase
  end
endmodule : fpsfl_cc_sel

/* fpsfl_flag_upd.sv */
`timescale 1ns/1ps
// Combinational sticky-flag update for the six flags and stack fault.
module fpsfl_flag_upd
  import fpsfl_pkg::*;
(
  // Inputs
  input wire fpsfl_op_t op,
  input wire logic [6:0] cur,
  // Outputs
  output logic [6:0] next_flags
);
  // One op per cycle, so a clear op carries no new exceptions; a clear
  // and event in the same op would be the clear op's own, which wins.
  wire logic clr = op.valid && (op.cls == FPSFL_CLEAR || op.cls == FPSFL_REINIT ||
    op.cls == FPSFL_SAVE);
  wire logic ld = op.valid && op.cls == FPSFL_ENV_LOAD;
  wire logic [6:0] evt = op.valid ? {op.stack_fault, op.exc} : 7'h00;
  always_comb
  begin
    if (ld)
      next_flags = op.image[6:0];
    else if (clr)
      next_flags = 7'h00;
    else
      next_flags = cur | evt;
  end
endmodule : fpsfl_flag_upd

//==============================================================================
// Status word register
module fpsfl_status_word
  import fpsfl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Datapath and control word masks
  input wire fpsfl_op_t op,
  input wire logic [5:0] ctrl_mask,
  // Status outputs
  output logic [15:0] status_word,
  output logic exc_request
);
  // Current fields picked out of the register.
  wire logic [6:0] cur_flags = status_word[STACK_FAULT_POS:FLAG_LSB];
  wire logic [3:0] cur_cc = {status_word[COND3_POS], status_word[COND2_POS],
    status_word[COND1_POS], status_word[COND0_POS]};
  wire logic [2:0] cur_top = status_word[TOP_LSB +: 3];
  logic [6:0] next_flags;
  logic [3:0] next_cc;
  logic [15:0] next_sw;

  fpsfl_flag_upd u_flags (.op(op), .cur(cur_flags), .next_flags(next_flags));
  fpsfl_cc_sel u_cc (.op(op), .cur(cur_cc), .next_cc(next_cc));

  // Stack pointer: image on restore, zero on reinit or save, else datapath.
  wire logic img_load = op.valid && op.cls == FPSFL_ENV_LOAD;
  wire logic top_zero = op.valid && (op.cls == FPSFL_REINIT || op.cls == FPSFL_SAVE);
  wire logic top_write = op.valid && op.top_we;
  wire logic [2:0] next_top = img_load ? op.image[TOP_LSB +: 3] :
    top_zero ? TOP_RESET : top_write ? op.top : cur_top;
  // Summary uses the live masks, so unmasking an old flag raises it at the next clock edge.
  wire logic next_summary = |(next_flags[FLAG_W-1:0] & ~ctrl_mask);

  // Assemble the next word field by field.
  always_comb
  begin
    next_sw = SW_RESET;
    next_sw[STACK_FAULT_POS:FLAG_LSB] = next_flags;
    next_sw[SUMMARY_POS] = next_summary;
    next_sw[COND0_POS] = next_cc[0];
    next_sw[COND1_POS] = next_cc[1];
    next_sw[COND2_POS] = next_cc[2];
    next_sw[TOP_LSB +: 3] = next_top;
    next_sw[COND3_POS] = next_cc[3];
    next_sw[B_POS] = next_summary;
  end

  // The word and the handler request leave straight from flip-flops.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_word <= SW_RESET;
      exc_request <= 1'b0;
    end
    else
    begin
      status_word <= next_sw;
      exc_request <= next_summary;
    end
  end

  //============================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_clear_issued;
    op.valid && op.cls == FPSFL_CLEAR;
  endsequence
  sequence s_init_issued;
    op.valid && (op.cls == FPSFL_REINIT || op.cls == FPSFL_SAVE);
  endsequence
  sequence s_fault_kept;
    op.valid && op.stack_fault && op.cls != FPSFL_CLEAR && op.cls != FPSFL_REINIT &&
      op.cls != FPSFL_SAVE && op.cls != FPSFL_ENV_LOAD;
  endsequence

  a_mirror_bit: assert property (status_word[B_POS] == status_word[SUMMARY_POS])
    else $error("legacy bit differs from summary");
  a_summary_gate: assert property (status_word[SUMMARY_POS] ==
    |(status_word[FLAG_W-1:0] & ~$past(ctrl_mask)))
    else $error("summary does not match unmasked flags");
  a_handler_request: assert property (exc_request == status_word[SUMMARY_POS])
    else $error("handler request differs from summary");
  a_flags_sticky: assert property (!op.valid |=>
    $stable(status_word[STACK_FAULT_POS:FLAG_LSB]))
    else $error("flags changed with no instruction");
  a_fault_sets: assert property (s_fault_kept |=> status_word[STACK_FAULT_POS])
    else $error("stack fault not recorded");
  a_clear_wipes: assert property (s_clear_issued |=>
    status_word[STACK_FAULT_POS:FLAG_LSB] == 7'h00)
    else $error("clear left flags set");
  a_init_cond: assert property (s_init_issued |=>
    {status_word[COND3_POS], status_word[COND2_POS], status_word[COND1_POS],
    status_word[COND0_POS]} == 4'h0)
    else $error("condition bits not zeroed by init");
endmodule : fpsfl_status_word

/* fpsfl_dp_model.sv */
`timescale 1ns/1ps
// Datapath stand-in that hands over one completed instruction at most every other cycle.
module fpsfl_dp_model
  import fpsfl_pkg::*;
(
  // Clock
  input wire logic clk,
  // Completed instruction
  output fpsfl_op_t op
);
  // Park the bus with no instruction.
  task automatic idle;
    op <= '0;
  endtask : idle
  // Valid for exactly one rising edge, then idle, so no event counts twice.
  // The word is settled at the falling edge on return; t is {top_we, top}.
  task automatic issue(input fpsfl_class_t c, input logic [5:0] e, input logic f,
    input logic o, input logic [3:0] k, input logic [3:0] t, input logic [15:0] img);
    @(posedge clk);
    op <= '{1'b1, c, e, f, o, k, t[3], t[2:0], img};
    @(posedge clk);
    op <= '0;
    @(negedge clk);
  endtask : issue
endmodule : fpsfl_dp_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import fpsfl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] ctrl_mask = 6'h3f;
  logic [15:0] sw;
  logic exc_req;
  int fails = 0;
  int checks_done = 0;
  fpsfl_op_t op;
  fpsfl_dp_model dp (.clk(clk), .op(op));
  fpsfl_status_word uut (.clk(clk), .rst_b(rst_b), .op(op), .ctrl_mask(ctrl_mask),
    .status_word(sw), .exc_request(exc_req));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Case equality so an unknown never passes.
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Compare with no fault drops cond bit 1 even when offered high.
  task automatic t_compare;
    dp.issue(FPSFL_COMPARE_CC, 6'h00, 1'b0, 1'b0, 4'hf, 4'h0, 16'h0000);
    chk("sw_cmp", 16'h4500, sw);
  endtask : t_compare
  // Fault type rides on cond bit 1; masked flags never raise the summary.
  task automatic t_fault;
    dp.issue(FPSFL_ARITH, 6'h01, 1'b1, 1'b1, 4'h0, 4'h0, 16'h0000);
    chk("sw_over", 16'h4741, sw);
    dp.issue(FPSFL_LOADMOVE, 6'h01, 1'b1, 1'b0, 4'h2, 4'h0, 16'h0000);
    chk("sw_under", 16'h4541, sw);
    chk("req_masked", 16'h0000, {15'h0000, exc_req});
  endtask : t_fault
  // Unmasking invalid raises summary, mirror bit and handler request.
  task automatic t_summary;
    @(posedge clk);
    ctrl_mask <= 6'h3e;
    dp.issue(FPSFL_ARITH, 6'h04, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000);
    chk("sw_summary", 16'hc5c5, sw);
    chk("req_unmasked", 16'h0001, {15'h0000, exc_req});
    dp.issue(FPSFL_CLEAR, 6'h3f, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000);
    chk("sw_clear", 16'h4500, sw);
  endtask : t_summary
  // Restore loads flags, codes and stack pointer; remainder reports quotient.
  task automatic t_envload;
    dp.issue(FPSFL_ENV_LOAD, 6'h00, 1'b0, 1'b0, 4'h0, 4'h0, 16'h7a05);
    chk("sw_env", 16'hfa85, sw);
    dp.issue(FPSFL_REMAINDER, 6'h00, 1'b0, 1'b0, 4'hb, 4'h0, 16'h0000);
    chk("sw_rem", 16'hfb85, sw);
  endtask : t_envload
  // Reinit, pointer write, trig, examine, compare-to-flags, then save.
  task automatic t_classes;
    dp.issue(FPSFL_REINIT, 6'h00, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000);
    chk("sw_reinit", 16'h0000, sw);
    dp.issue(FPSFL_LOADMOVE, 6'h00, 1'b0, 1'b0, 4'h2, 4'hd, 16'h0000);
    chk("sw_top", 16'h2800, sw);
    dp.issue(FPSFL_TRIG, 6'h00, 1'b0, 1'b0, 4'h6, 4'h0, 16'h0000);
    chk("sw_trig", 16'h2e00, sw);
    dp.issue(FPSFL_EXAMINE, 6'h00, 1'b0, 1'b0, 4'h9, 4'h0, 16'h0000);
    chk("sw_exam", 16'h6900, sw);
    dp.issue(FPSFL_COMPARE_FLAGS, 6'h00, 1'b1, 1'b1, 4'h0, 4'h0, 16'h0000);
    chk("sw_cmpf", 16'h6b40, sw);
    dp.issue(FPSFL_SAVE, 6'h00, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000);
    chk("sw_save", 16'h0000, sw);
  endtask : t_classes
  // Mid-run reset wipes recorded flags.
  task automatic t_reset;
    dp.issue(FPSFL_ARITH, 6'h02, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000);
    chk("sw_pre", 16'h0002, sw);
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    chk("sw_reset", 16'h0000, sw);
    @(posedge clk);
    rst_b <= 1'b1;
  endtask : t_reset
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Main sequence after reset.
  initial
  begin
    dp.idle();
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_compare();
    t_fault();
    t_summary();
    t_envload();
    t_classes();
    t_reset();
    final_report();
  end
  // Watchdog: the scenarios need well under a hundred cycles.
  initial
  begin
    #20000;
    fails++;
    final_report();
  end
endmodule : tb_top
